/* File: bench/acs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_miso,
  output var  logic        o_sclk,
  output var  logic        o_cs_n,
  output var  logic        o_mosi,
  output var  logic        o_rd_done,
  output var  logic [15:0] o_rd_data
);
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_mosi = 1'b1;
    o_rd_done = 1'b0;
    o_rd_data = 16'h0000;
  end
  // ****************
  // Serial frame
  // ****************
  // Half periods of five clocks keep the design's synchronisers well inside their margin.
  task automatic xfer(input logic [15:0] w, input logic rd_flag);
    logic [15:0] r;
    r = 16'h0000;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    for (int i = 15; i >= 0; i--) begin
      o_sclk <= 1'b0;
      o_mosi <= w[i];
      repeat (5) @(posedge i_clk);
      o_sclk <= 1'b1;
      r = {r[14:0], i_miso};
      repeat (5) @(posedge i_clk);
    end
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi;
    repeat (8) @(posedge i_clk);
    if (rd_flag) begin
      o_rd_data <= r;
      o_rd_done <= 1'b1;
      @(posedge i_clk);
      o_rd_done <= 1'b0;
    end
  endtask
endmodule // acs_host_model
`default_nettype wire

/* File: bench/acs_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_top_monitor #(
  parameter integer TB_FAST_CYC = 8,
  parameter integer TB_SLOW_CYC = 20
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_por_n,
  input wire logic i_misc_claim0,
  input wire logic i_misc_claim1,
  input wire logic i_misc_out0,
  input wire logic i_misc_out1,
  input wire logic i_gpio_oe0,
  input wire logic i_gpio_oe1,
  input wire logic o_sample_update,
  input wire logic o_alarm1_active,
  input wire logic o_alarm2_active,
  input wire logic o_pin0_out,
  input wire logic o_pin0_oe,
  input wire logic o_pin1_out,
  input wire logic o_pin1_oe
);
  // ****************
  // Helper counters
  // ****************
  wire logic  rst_ok_n;
  wire logic  free0;
  wire logic  free1;
  logic [31:0] gap_reg;
  logic [2:0]  age_reg;
  assign rst_ok_n = i_rst_n & i_por_n;
  assign free0 = !i_misc_claim0 && !i_gpio_oe0;
  assign free1 = !i_misc_claim1 && !i_gpio_oe1;
  always_ff @(posedge i_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      gap_reg <= 32'h0;
      age_reg <= 3'h0;
    end else begin
      gap_reg <= o_sample_update ? 32'h0 : gap_reg + 32'h1;
      if (age_reg != 3'h7) begin
        age_reg <= age_reg + 3'h1;
      end
    end
  end
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_ok_n);
  pulse_single_a: assert property (o_sample_update |=> !o_sample_update)
    else $error("update pulse longer than one cycle");
  period_floor_a: assert property (o_sample_update && age_reg == 3'h7 |->
    gap_reg >= TB_FAST_CYC - 1) else $error("sample period shorter than one time base");
  period_ceiling_a: assert property (gap_reg <= 128 * TB_SLOW_CYC + 4)
    else $error("sample period longer than the slowest setting");
  alarm1_timing_a: assert property (!$stable(o_alarm1_active) |->
    $past(o_sample_update, 3)) else $error("alarm 1 changed away from an update");
  alarm2_timing_a: assert property (!$stable(o_alarm2_active) |->
    $past(o_sample_update, 3)) else $error("alarm 2 changed away from an update");
  pin0_misc_a: assert property (age_reg == 3'h7 && i_misc_claim0 && $past(i_misc_claim0)
    && $stable(i_misc_out0) |-> o_pin0_oe && o_pin0_out == i_misc_out0)
    else $error("pin 0 not given to miscellaneous control");
  pin1_misc_a: assert property (age_reg == 3'h7 && i_misc_claim1 && $past(i_misc_claim1)
    && $stable(i_misc_out1) |-> o_pin1_oe && o_pin1_out == i_misc_out1)
    else $error("pin 1 not given to miscellaneous control");
  one_alarm_pin_a: assert property (age_reg == 3'h7 && free0 && free1 && $past(free0)
    && $past(free1) |-> !(o_pin0_oe && o_pin1_oe)) else $error("alarm drives both pins");
  cover property (o_sample_update);
  cover property ($rose(o_alarm1_active));
  cover property ($rose(o_alarm2_active));
  cover property (o_pin1_oe && free1);
endmodule // acs_top_monitor
bind acs_top acs_top_monitor #(.TB_FAST_CYC(TB_FAST_CYC), .TB_SLOW_CYC(TB_SLOW_CYC)) u_mon (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n), .i_misc_claim0(i_misc_claim0),
  .i_misc_claim1(i_misc_claim1), .i_misc_out0(i_misc_out0), .i_misc_out1(i_misc_out1),
  .i_gpio_oe0(i_gpio_oe0), .i_gpio_oe1(i_gpio_oe1), .o_sample_update(o_sample_update),
  .o_alarm1_active(o_alarm1_active), .o_alarm2_active(o_alarm2_active),
  .o_pin0_out(o_pin0_out), .o_pin0_oe(o_pin0_oe), .o_pin1_out(o_pin1_out),
  .o_pin1_oe(o_pin1_oe));
`default_nettype wire

/* File: bench/acs_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.vh"
module acs_top_tb;
  localparam integer FAST = 8;
  localparam integer SLOW = 20;
  localparam integer LIMIT = 40000;
  logic        clk, rst_n, por_n, claim0, claim1, mout0, mout1, goe0, goe1, gout0, gout1;
  logic [13:0] raw [0:4];
  logic [13:0] filt [0:4];
  logic [15:0] exp_q [$];
  logic [15:0] cv, rv;
  logic [7:0]  plist [0:3];
  wire logic   sclk, cs_n, mosi, miso, miso_oe, upd, al1, al2, p0o, p0e, p1o, p1e, rd_done;
  wire logic [15:0] rd_data;
  int          errors, compares, cyc, seed, n;
  acs_top #(.TB_FAST_CYC(FAST), .TB_SLOW_CYC(SLOW)) DUT (
    .i_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe), .i_supply_raw(raw[0]),
    .i_supply_filt(filt[0]), .i_aux_raw(raw[1]), .i_aux_filt(filt[1]), .i_temp_raw(raw[2]),
    .i_temp_filt(filt[2]), .i_full_angle_raw(raw[3]), .i_full_angle_filt(filt[3]),
    .i_signed_angle_raw(raw[4]), .i_signed_angle_filt(filt[4]), .i_misc_claim0(claim0),
    .i_misc_claim1(claim1), .i_misc_out0(mout0), .i_misc_out1(mout1), .i_gpio_oe0(goe0),
    .i_gpio_oe1(goe1), .i_gpio_out0(gout0), .i_gpio_out1(gout1), .o_sample_update(upd),
    .o_alarm1_active(al1), .o_alarm2_active(al2), .o_pin0_out(p0o), .o_pin0_oe(p0e),
    .o_pin1_out(p1o), .o_pin1_oe(p1e));
  acs_host_model host (.i_clk(clk), .i_miso(miso), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_mosi(mosi), .o_rd_done(rd_done), .o_rd_data(rd_data));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // ****************
  // Checking and closing
  // ****************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      $display("[FAIL] %0t run did not finish", $time);
      end_sim();
    end
  end
  always @(posedge clk) begin
    if (rd_done === 1'b1) begin
      check(rd_data, exp_q.pop_front());
    end
  end
  // ****************
  // Bus and timing helpers
  // ****************
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.xfer({2'b10, a, d}, 1'b0);
  endtask
  task automatic wr16(input logic [5:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 6'h01, v[15:8]);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.xfer({2'b00, a, 8'h00}, 1'b0);
    host.xfer(16'h0000, 1'b1);
  endtask
  task automatic pulse_wait();
    do @(posedge clk); while (upd !== 1'b1);
  endtask
  task automatic settle();
    pulse_wait();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic resets(input logic por);
    @(posedge clk);
    rst_n <= por;
    por_n <= !por;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic pin_case(input logic [7:0] lo, input logic [5:0] ins, input logic [3:0] e);
    @(posedge clk);
    {claim0, mout0, goe0, gout0, goe1, gout1} <= ins;
    wr(`ACS_ADDR_ALARM_CONTROL, lo);
    settle();
    check({12'h0, p0e, p0o, p1e, p1o}, {12'h0, e});
  endtask
  task automatic roc_run(input logic [13:0] step);
    repeat (4) begin
      pulse_wait();
      raw[2] <= raw[2] + step;
    end
    settle();
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    seed = 63;
    {errors, compares, cyc} = '0;
    {rst_n, por_n, claim0, claim1, mout0, mout1, goe0, goe1, gout0, gout1} = '0;
    plist = '{8'h01, 8'h06, 8'h7F, 8'h81};
    for (int j = 0; j < 5; j++) begin
      raw[j] = 14'h0000;
      filt[j] = 14'h0000;
    end
    resets(1'b1);
    rd(`ACS_ADDR_ALARM_CONTROL, 16'h0000);
    rd(`ACS_ADDR_SMPL_PER, 16'h0008);
    rd(`ACS_ADDR_ALM2_RCNT, 16'h0000);
    cv = $random(seed);
    rv = $random(seed);
    wr16(`ACS_ADDR_ALARM_CONTROL, cv);
    rd(`ACS_ADDR_ALARM_CONTROL, cv & `ACS_AC_USED_MASK);
    wr16(`ACS_ADDR_ALM2_RCNT, rv);
    rd(`ACS_ADDR_ALM2_RCNT, {8'h00, rv[7:0]});
    wr(6'h30, rv[15:8]);
    rd(6'h30, 16'h0000);
    wr(`ACS_ADDR_SMPL_PER, 8'h85);
    resets(1'b0);
    rd(`ACS_ADDR_ALM2_RCNT, {8'h00, rv[7:0]});
    rd(`ACS_ADDR_SMPL_PER, 16'h0085);
    rd(`ACS_ADDR_ALARM_CONTROL, cv & `ACS_AC_USED_MASK);
    resets(1'b1);
    rd(`ACS_ADDR_SMPL_PER, 16'h0008);
    rd(`ACS_ADDR_ALARM_CONTROL, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      wr(`ACS_ADDR_SMPL_PER, plist[k]);
      pulse_wait();
      pulse_wait();
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (upd !== 1'b1);
      check(n[15:0], 16'((plist[k][6:0] + 1) * (plist[k][7] ? SLOW : FAST)));
    end
    wr(`ACS_ADDR_SMPL_PER, 8'h01);
    wr16(`ACS_ADDR_ALM1_THR, 16'h8800);
    wr16(`ACS_ADDR_ALM2_THR, 16'h8800);
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      for (int j = 0; j < 5; j++) begin
        raw[j] <= (j == ((c == 1) ? 0 : (c > 3) ? c - 3 : 9)) ? 14'h1000 : 14'h0010;
      end
      wr(`ACS_ADDR_ALARM_CONTROL + 6'h01, {1'b0, 3'(c), 1'b0, 3'(c)});
      settle();
      check({14'h0, al2, al1}, (c == 1 || c > 3) ? 16'h0003 : 16'h0000);
    end
    wr(`ACS_ADDR_ALARM_CONTROL + 6'h01, 8'h77);
    wr(`ACS_ADDR_ALARM_CONTROL, 8'h30);
    settle();
    check({14'h0, al2, al1}, 16'h0000);
    wr(`ACS_ADDR_ALARM_CONTROL, 8'h20);
    settle();
    check({14'h0, al2, al1}, 16'h0001);
    pin_case(8'h06, 6'b000000, 4'b1100);
    pin_case(8'h05, 6'b000000, 4'b0010);
    pin_case(8'h01, 6'b000000, 4'b0000);
    pin_case(8'h06, 6'b100000, 4'b1000);
    pin_case(8'h06, 6'b001011, 4'b1111);
    @(posedge clk);
    {claim1, mout1} <= 2'b10;
    pin_case(8'h07, 6'b000000, 4'b0010);
    @(posedge clk);
    claim1 <= 1'b0;
    pin_case(8'h00, 6'b000000, 4'b0000);
    @(posedge clk);
    raw[2] <= 14'h0400;
    wr(`ACS_ADDR_ALM2_RCNT, 8'h01);
    wr16(`ACS_ADDR_ALM2_THR, 16'h8010);
    wr(`ACS_ADDR_ALARM_CONTROL + 6'h01, 8'hD0);
    roc_run(14'h0100);
    check({15'h0, al2}, 16'h0001);
    roc_run(14'h0000);
    check({15'h0, al2}, 16'h0000);
    wr(`ACS_ADDR_ALARM_CONTROL + 6'h01, 8'h50);
    settle();
    check({15'h0, al2}, 16'h0001);
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule // acs_top_tb
`default_nettype wire

/* File: hw/acs_alarm_chan.v */
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.vh"

// ***********************************************
// One alarm comparator, threshold or rate of change.
// ***********************************************
module acs_alarm_chan (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_eval,
  input  wire [2:0]  i_src,
  input  wire        i_roc,
  input  wire [13:0] i_value,
  input  wire        i_signed,
  input  wire [15:0] i_thr,
  input  wire [7:0]  i_rcnt,
  output reg         o_active
);

  reg  [7:0]  win_cnt_reg;
  reg  [13:0] base_reg;
  wire        src_ok;
  wire        above;
  wire [7:0]  n_eff;
  wire signed [14:0] val_s;
  wire signed [14:0] thr_s;
  wire signed [14:0] base_s;
  wire signed [15:0] diff;
  wire signed [23:0] roc_lim;
  wire        thr_hit;
  wire        roc_hit;

  assign src_ok = (i_src == `ACS_SRC_SUPPLY) || (i_src == `ACS_SRC_AUX) ||
                  (i_src == `ACS_SRC_TEMP) || (i_src == `ACS_SRC_FULL_ANGLE) ||
                  (i_src == `ACS_SRC_SIGNED_ANGLE);
  assign above  = i_thr[`ACS_THR_ABOVE];
  assign val_s  = i_signed ? {i_value[13], i_value} : {1'b0, i_value};
  assign thr_s  = i_signed ? {i_thr[13], i_thr[13:0]} : {1'b0, i_thr[13:0]};
  assign base_s = i_signed ? {base_reg[13], base_reg} : {1'b0, base_reg};
  assign thr_hit = above ? (val_s > thr_s) : (val_s < thr_s);
  assign n_eff   = (i_rcnt == 8'h00) ? 8'h01 : i_rcnt;
  assign diff    = {val_s[14], val_s} - {base_s[14], base_s};
  // Average change compared by scaling the limit instead of dividing.
  assign roc_lim = $signed({i_thr[13], i_thr[13:0]}) * $signed({1'b0, n_eff});
  assign roc_hit = above ? ($signed({{8{diff[15]}}, diff}) > roc_lim) :
                           ($signed({{8{diff[15]}}, diff}) < roc_lim);

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_active    <= 1'b0;
      win_cnt_reg <= 8'h00;
      base_reg    <= 14'h0000;
    end else if (i_eval) begin
      if (!src_ok) begin
        o_active    <= 1'b0;
        win_cnt_reg <= 8'h00;
      end else if (!i_roc) begin
        o_active    <= thr_hit;
        win_cnt_reg <= 8'h00;
      end else if (win_cnt_reg == 8'h00) begin
        base_reg    <= i_value;
        win_cnt_reg <= n_eff;
      end else if (win_cnt_reg == 8'h01) begin
        o_active    <= roc_hit;
        base_reg    <= i_value;
        win_cnt_reg <= n_eff;
      end else begin
        win_cnt_reg <= win_cnt_reg - 8'h01;
      end
    end
  end

endmodule // acs_alarm_chan

`default_nettype wire

/* File: hw/acs_defines.vh */
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// Register byte addresses, lower byte of each 16-bit register.
`define ACS_ADDR_ALM1_THR      6'h20
`define ACS_ADDR_ALM2_THR      6'h22
`define ACS_ADDR_ALM1_RCNT     6'h24
`define ACS_ADDR_ALM2_RCNT     6'h26
`define ACS_ADDR_ALARM_CONTROL      6'h28
`define ACS_ADDR_SMPL_PER      6'h36

// Reset values of the nonvolatile registers.
`define ACS_RST_ALM_THR        16'h0000
`define ACS_RST_RCNT           8'h00
`define ACS_RST_ALARM_CONTROL       16'h0000
`define ACS_RST_SMPL_PER       8'h08

// Alarm control field positions.
`define ACS_AC_ROC2            15
`define ACS_AC_SRC2_HI         14
`define ACS_AC_SRC2_LO         12
`define ACS_AC_ROC1            11
`define ACS_AC_SRC1_HI         10
`define ACS_AC_SRC1_LO         8
`define ACS_AC_FILT2           5
`define ACS_AC_FILT1           4
`define ACS_AC_OUT_EN          2
`define ACS_AC_OUT_POL         1
`define ACS_AC_OUT_PIN         0
`define ACS_AC_USED_MASK       16'hFF37
`define ACS_AC_USED_LO         8'h37

// Alarm source encodings.
`define ACS_SRC_OFF            3'h0
`define ACS_SRC_SUPPLY         3'h1
`define ACS_SRC_AUX            3'h4
`define ACS_SRC_TEMP           3'h5
`define ACS_SRC_FULL_ANGLE     3'h6
`define ACS_SRC_SIGNED_ANGLE   3'h7

// Threshold field positions.
`define ACS_THR_ABOVE          15
`define ACS_THR_LIM_HI         13

// Sample period field positions.
`define ACS_SP_TB_BIT          7
`define ACS_SP_CNT_HI          6

// Timing: clock period and the two time bases, in ns.
`define ACS_CLK_NS             10
`define ACS_TB_FAST_NS         122100
`define ACS_TB_SLOW_NS         3784000
`define ACS_TB_FAST_CYC        (`ACS_TB_FAST_NS / `ACS_CLK_NS)
`define ACS_TB_SLOW_CYC        (`ACS_TB_SLOW_NS / `ACS_CLK_NS)

// Serial frame layout.
`define ACS_SPI_BITS           16
`define ACS_SPI_WR_BIT         15
`define ACS_SPI_LAST           5'h0F

`endif

/* File: hw/acs_top.v */
// Behaviour
// - Alarm 2 window length from count bits 7:0.
// - Alarm 2 window count survives ordinary reset.
// - Bit 15 picks Alarm 2 threshold or rate.
// - Bits 14:12 pick Alarm 2 source.
// - Bit 11 picks Alarm 1 threshold or rate.
// - Bits 10:8 pick Alarm 1 source.
// - Bits 5 and 4 pick filtered data.
// - Bit 2 enables the alarm pin output.
// - Bit 1 polarity, bit 0 picks pin.
// - Period covers sample, process and update.
// - Alarm outputs and the alarm pin update together every period, or only at each window end in rate mode.
// - Bit 7 picks fast or slow time base.
// - Period is count plus one times base.
// - Period setting survives ordinary reset.
// - Threshold bit 15 above/below, 14-bit limit.
// - One pin shows either alarm.
// - Misc control over alarm over general pins.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.vh"

module acs_top #(
  parameter integer TB_FAST_CYC = `ACS_TB_FAST_CYC,
  parameter integer TB_SLOW_CYC = `ACS_TB_SLOW_CYC
) (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_por_n,
  input  wire        i_sclk,
  input  wire        i_cs_n,
  input  wire        i_mosi,
  output reg         o_miso,
  output reg         o_miso_oe,
  input  wire [13:0] i_supply_raw,
  input  wire [13:0] i_supply_filt,
  input  wire [13:0] i_aux_raw,
  input  wire [13:0] i_aux_filt,
  input  wire [13:0] i_temp_raw,
  input  wire [13:0] i_temp_filt,
  input  wire [13:0] i_full_angle_raw,
  input  wire [13:0] i_full_angle_filt,
  input  wire [13:0] i_signed_angle_raw,
  input  wire [13:0] i_signed_angle_filt,
  input  wire        i_misc_claim0,
  input  wire        i_misc_claim1,
  input  wire        i_misc_out0,
  input  wire        i_misc_out1,
  input  wire        i_gpio_oe0,
  input  wire        i_gpio_oe1,
  input  wire        i_gpio_out0,
  input  wire        i_gpio_out1,
  output reg         o_sample_update,
  output reg         o_alarm1_active,
  output reg         o_alarm2_active,
  output reg         o_pin0_out,
  output reg         o_pin0_oe,
  output reg         o_pin1_out,
  output reg         o_pin1_oe
);

  // ***********************************************
  // Reset release and input synchronisers.
  // ***********************************************
  reg  [1:0]  rst_sync_reg;
  reg  [1:0]  por_sync_reg;
  reg  [1:0]  sclk_sync_reg;
  reg  [1:0]  cs_sync_reg;
  reg  [1:0]  mosi_sync_reg;
  reg         sclk_d_reg;
  wire        rst_n;
  wire        por_n;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  always @(posedge i_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      por_sync_reg <= 2'h0;
    end else begin
      por_sync_reg <= {por_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1] & por_sync_reg[1];
  assign por_n = por_sync_reg[1];

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_reg <= 2'h3;
      cs_sync_reg   <= 2'h3;
      mosi_sync_reg <= 2'h0;
      sclk_d_reg    <= 1'b1;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], i_sclk};
      cs_sync_reg   <= {cs_sync_reg[0], i_cs_n};
      mosi_sync_reg <= {mosi_sync_reg[0], i_mosi};
      sclk_d_reg    <= sclk_sync_reg[1];
    end
  end

  // ***********************************************
  // Serial slave: 16-bit frames, sample on rising clock.
  // ***********************************************
  reg  [15:0] rx_reg;
  reg  [15:0] tx_reg;
  reg  [4:0]  bit_cnt_reg;
  reg  [5:0]  rd_addr_reg;
  reg         wr_stb_reg;
  reg  [5:0]  wr_addr_reg;
  reg  [7:0]  wr_data_reg;
  reg  [15:0] rd_word;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        cs_act;
  wire [15:0] rx_next;

  assign sclk_rise = sclk_sync_reg[1] & ~sclk_d_reg;
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_d_reg;
  assign cs_act    = ~cs_sync_reg[1];
  assign rx_next   = {rx_reg[14:0], mosi_sync_reg[1]};

  // ***********************************************
  // Nonvolatile registers, cleared only at power-on.
  // ***********************************************
  reg  [15:0] alm1_thr_reg;
  reg  [15:0] alm2_thr_reg;
  reg  [7:0]  alm1_rcnt_reg;
  reg  [7:0]  alm2_rcnt_reg;
  reg  [15:0] alarm_control_reg;
  reg  [7:0]  smpl_per_reg;

  always @* begin
    case ({rd_addr_reg[5:1], 1'b0})
      `ACS_ADDR_ALM1_THR:  rd_word = alm1_thr_reg;
      `ACS_ADDR_ALM2_THR:  rd_word = alm2_thr_reg;
      `ACS_ADDR_ALM1_RCNT: rd_word = {8'h00, alm1_rcnt_reg};
      `ACS_ADDR_ALM2_RCNT: rd_word = {8'h00, alm2_rcnt_reg};
      `ACS_ADDR_ALARM_CONTROL:  rd_word = alarm_control_reg;
      `ACS_ADDR_SMPL_PER:  rd_word = {8'h00, smpl_per_reg};
      default:             rd_word = 16'h0000;
    endcase
  end

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg      <= 16'h0000;
      tx_reg      <= 16'h0000;
      bit_cnt_reg <= 5'h00;
      rd_addr_reg <= 6'h00;
      wr_stb_reg  <= 1'b0;
      wr_addr_reg <= 6'h00;
      wr_data_reg <= 8'h00;
      o_miso      <= 1'b0;
      o_miso_oe   <= 1'b0;
    end else begin
      wr_stb_reg <= 1'b0;
      o_miso_oe  <= cs_act;
      if (!cs_act) begin
        bit_cnt_reg <= 5'h00;
        tx_reg      <= rd_word;
        o_miso      <= rd_word[15];
      end else begin
        if (sclk_fall && bit_cnt_reg != 5'h00) begin
          o_miso <= tx_reg[15];
        end
        if (sclk_rise) begin
          rx_reg      <= rx_next;
          tx_reg      <= {tx_reg[14:0], 1'b0};
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == `ACS_SPI_LAST) begin
            bit_cnt_reg <= 5'h00;
            if (rx_next[`ACS_SPI_WR_BIT]) begin
              wr_stb_reg  <= 1'b1;
              wr_addr_reg <= rx_next[13:8];
              wr_data_reg <= rx_next[7:0];
            end else begin
              rd_addr_reg <= rx_next[13:8];
            end
          end
        end
      end
    end
  end

  always @(posedge i_clk or negedge por_n) begin
    if (!por_n) begin
      alm1_thr_reg  <= `ACS_RST_ALM_THR;
      alm2_thr_reg  <= `ACS_RST_ALM_THR;
      alm1_rcnt_reg <= `ACS_RST_RCNT;
      alm2_rcnt_reg <= `ACS_RST_RCNT;
      alarm_control_reg  <= `ACS_RST_ALARM_CONTROL;
      smpl_per_reg  <= `ACS_RST_SMPL_PER;
    end else if (wr_stb_reg) begin
      case (wr_addr_reg)
        `ACS_ADDR_ALM1_THR:       alm1_thr_reg[7:0]   <= wr_data_reg;
        `ACS_ADDR_ALM1_THR + 6'h1: alm1_thr_reg[15:8] <= wr_data_reg & 8'hBF;
        `ACS_ADDR_ALM2_THR:       alm2_thr_reg[7:0]   <= wr_data_reg;
        `ACS_ADDR_ALM2_THR + 6'h1: alm2_thr_reg[15:8] <= wr_data_reg & 8'hBF;
        `ACS_ADDR_ALM1_RCNT:      alm1_rcnt_reg       <= wr_data_reg;
        `ACS_ADDR_ALM2_RCNT:      alm2_rcnt_reg       <= wr_data_reg;
        `ACS_ADDR_ALARM_CONTROL:       alarm_control_reg[7:0]   <= wr_data_reg & `ACS_AC_USED_LO;
        `ACS_ADDR_ALARM_CONTROL + 6'h1: alarm_control_reg[15:8] <= wr_data_reg;
        `ACS_ADDR_SMPL_PER:       smpl_per_reg        <= wr_data_reg;
        default: ;
      endcase
    end
  end

  // ***********************************************
  // Sample period timer.
  // ***********************************************
  reg  [18:0] tb_cnt_reg;
  reg  [6:0]  per_cnt_reg;
  reg         eval_reg;
  wire [18:0] tb_last;
  wire        tb_tick;
  wire        per_wr;

  localparam [31:0] FAST_LAST = TB_FAST_CYC - 1;
  localparam [31:0] SLOW_LAST = TB_SLOW_CYC - 1;

  assign tb_last = smpl_per_reg[`ACS_SP_TB_BIT] ? SLOW_LAST[18:0] : FAST_LAST[18:0];
  assign tb_tick = (tb_cnt_reg >= tb_last);
  // A new period setting restarts the timer so no period is ever cut short.
  assign per_wr  = wr_stb_reg && (wr_addr_reg == `ACS_ADDR_SMPL_PER);

  // ***********************************************
  // Alarm data selection, latched on each update.
  // ***********************************************
  reg  [13:0] a1_val_reg;
  reg  [13:0] a2_val_reg;
  wire        a1_act;
  wire        a2_act;

  function [13:0] pick;
    input [2:0] src;
    input       filt;
    input [13:0] s_r, s_f, x_r, x_f, t_r, t_f, f_r, f_f, g_r, g_f;
    begin
      case (src)
        `ACS_SRC_SUPPLY:       pick = filt ? s_f : s_r;
        `ACS_SRC_AUX:          pick = filt ? x_f : x_r;
        `ACS_SRC_TEMP:         pick = filt ? t_f : t_r;
        `ACS_SRC_FULL_ANGLE:   pick = filt ? f_f : f_r;
        `ACS_SRC_SIGNED_ANGLE: pick = filt ? g_f : g_r;
        default:               pick = 14'h0000;
      endcase
    end
  endfunction

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tb_cnt_reg      <= 19'h00000;
      per_cnt_reg     <= 7'h00;
      o_sample_update <= 1'b0;
      eval_reg        <= 1'b0;
      a1_val_reg      <= 14'h0000;
      a2_val_reg      <= 14'h0000;
    end else begin
      o_sample_update <= 1'b0;
      eval_reg        <= o_sample_update;
      tb_cnt_reg      <= tb_tick ? 19'h00000 : tb_cnt_reg + 19'h00001;
      if (tb_tick) begin
        if (per_cnt_reg >= smpl_per_reg[`ACS_SP_CNT_HI:0]) begin
          per_cnt_reg <= 7'h00;
          o_sample_update <= 1'b1;
          a1_val_reg <= pick(alarm_control_reg[`ACS_AC_SRC1_HI:`ACS_AC_SRC1_LO],
                             alarm_control_reg[`ACS_AC_FILT1],
                             i_supply_raw, i_supply_filt, i_aux_raw, i_aux_filt,
                             i_temp_raw, i_temp_filt, i_full_angle_raw,
                             i_full_angle_filt, i_signed_angle_raw, i_signed_angle_filt);
          a2_val_reg <= pick(alarm_control_reg[`ACS_AC_SRC2_HI:`ACS_AC_SRC2_LO],
                             alarm_control_reg[`ACS_AC_FILT2],
                             i_supply_raw, i_supply_filt, i_aux_raw, i_aux_filt,
                             i_temp_raw, i_temp_filt, i_full_angle_raw,
                             i_full_angle_filt, i_signed_angle_raw, i_signed_angle_filt);
        end else begin
          per_cnt_reg <= per_cnt_reg + 7'h01;
        end
      end
      if (per_wr) begin
        tb_cnt_reg  <= 19'h00000;
        per_cnt_reg <= 7'h00;
      end
    end
  end

  acs_alarm_chan u_alarm1 (
    .i_clk    (i_clk),
    .i_rst_n  (rst_n),
    .i_eval   (eval_reg),
    .i_src    (alarm_control_reg[`ACS_AC_SRC1_HI:`ACS_AC_SRC1_LO]),
    .i_roc    (alarm_control_reg[`ACS_AC_ROC1]),
    .i_value  (a1_val_reg),
    .i_signed (alarm_control_reg[`ACS_AC_SRC1_HI:`ACS_AC_SRC1_LO] == `ACS_SRC_SIGNED_ANGLE),
    .i_thr    (alm1_thr_reg),
    .i_rcnt   (alm1_rcnt_reg),
    .o_active (a1_act)
  );

  acs_alarm_chan u_alarm2 (
    .i_clk    (i_clk),
    .i_rst_n  (rst_n),
    .i_eval   (eval_reg),
    .i_src    (alarm_control_reg[`ACS_AC_SRC2_HI:`ACS_AC_SRC2_LO]),
    .i_roc    (alarm_control_reg[`ACS_AC_ROC2]),
    .i_value  (a2_val_reg),
    .i_signed (alarm_control_reg[`ACS_AC_SRC2_HI:`ACS_AC_SRC2_LO] == `ACS_SRC_SIGNED_ANGLE),
    .i_thr    (alm2_thr_reg),
    .i_rcnt   (alm2_rcnt_reg),
    .o_active (a2_act)
  );

  // ***********************************************
  // Alarm pin routing and pin priority.
  // ***********************************************
  wire alm_en;
  wire alm_lvl;
  wire alm_on0;
  wire alm_on1;

  assign alm_en  = alarm_control_reg[`ACS_AC_OUT_EN];
  assign alm_lvl = (a1_act | a2_act) ~^ alarm_control_reg[`ACS_AC_OUT_POL];
  assign alm_on0 = alm_en & ~alarm_control_reg[`ACS_AC_OUT_PIN];
  assign alm_on1 = alm_en & alarm_control_reg[`ACS_AC_OUT_PIN];

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_alarm1_active <= 1'b0;
      o_alarm2_active <= 1'b0;
      o_pin0_out      <= 1'b0;
      o_pin0_oe       <= 1'b0;
      o_pin1_out      <= 1'b0;
      o_pin1_oe       <= 1'b0;
    end else begin
      o_alarm1_active <= a1_act;
      o_alarm2_active <= a2_act;
      o_pin0_oe  <= i_misc_claim0 | alm_on0 | i_gpio_oe0;
      o_pin0_out <= i_misc_claim0 ? i_misc_out0 : (alm_on0 ? alm_lvl : i_gpio_out0);
      o_pin1_oe  <= i_misc_claim1 | alm_on1 | i_gpio_oe1;
      o_pin1_out <= i_misc_claim1 ? i_misc_out1 : (alm_on1 ? alm_lvl : i_gpio_out1);
    end
  end

endmodule // acs_top

`default_nettype wire

/* File: hw/acs_top_note_unused.v */
`timescale 1ns/1ps
